// ==== dhba_pkg.sv ====
// Package with constants and carrier types for the dual host drive arbiter.
// What this block does
// - After grant, only the interface whose select setting matches the drive number connects.
// - Buffer all controller bus signals; decode attention requests and head position commands.
// - Leftmost arbiter, enabled by left controller, drives chain output disabling downstream arbiters.
// - Grant the bus to the first requester, assert its select, serve in arrival order.
// - Time each grant; force the bus free after three seconds of holding.
// - Single-controller systems: arbiter disabled, access always available, controller ignores it.
package dhba_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLOCK_HZ = 20_000_000;
    localparam int unsigned HOLD_LIMIT_S = 3;
    localparam longint unsigned HOLD_LIMIT_CYCLES =
        longint'(HOLD_LIMIT_S) * longint'(CLOCK_HZ);

    // ****************************************************************
    // Widths and field positions
    // ****************************************************************
    localparam int unsigned DRIVE_W = 2;
    localparam int unsigned CYL_W = 9;
    localparam int unsigned CMD_W = 2;
    localparam logic [CMD_W-1:0] CMD_SEEK = 2'h2;
    localparam logic [CMD_W-1:0] CMD_RECAL = 2'h3;
    localparam int unsigned HOST_LEFT = 0;
    localparam int unsigned HOST_RIGHT = 1;

    // ****************************************************************
    // Carrier types
    // ****************************************************************
    // Signals driven by a controller onto the shared bus.
    typedef struct packed {
        logic [DRIVE_W-1:0] drive;
        logic [CMD_W-1:0] cmd;
        logic [CYL_W-1:0] cyl;
        logic addr_strobe;
        logic attn_req;
    } dhba_ctl_bus_t;

    // Signals returned by the drive toward the controller.
    typedef struct packed {
        logic ready;
        logic seek_done;
        logic seek_error;
        logic unsafe;
    } dhba_drv_bus_t;

    // Position command decoded for the drive.
    typedef struct packed {
        logic valid;
        logic recal;
        logic [CYL_W-1:0] cyl;
    } dhba_pos_cmd_t;

    typedef enum logic [1:0] {
        ARB_IDLE = 2'b00,
        ARB_LEFT = 2'b01,
        ARB_RIGHT = 2'b10
    } dhba_arb_state_t;

endpackage

// ==== dhba_sync.sv ====
// Two flip-flop synchroniser for a vector of asynchronous levels.
`timescale 1ns/1ps
`default_nettype none
module dhba_sync
#(
    parameter int unsigned WIDTH = 1
)
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    // The first stage feeds only the second stage.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            stage1 <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // dhba_sync
`default_nettype wire

// ==== dhba_arbiter.sv ====
// Per-drive interface with the shared-bus arbiter for two controllers.
`timescale 1ns/1ps
`default_nettype none
module dhba_arbiter
    import dhba_pkg::*;
#(
    parameter longint unsigned HOLD_CYCLES = HOLD_LIMIT_CYCLES
)
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic dual_mode,
    input wire logic left_select_in,
    output logic left_select_out,
    input wire logic [1:0] request,
    input wire logic [1:0] finish,
    output logic [1:0] host_select,
    output logic timeout_release,
    input wire logic [DRIVE_W-1:0] select_switch,
    input wire dhba_ctl_bus_t ctl_bus,
    output dhba_ctl_bus_t drive_ctl,
    input wire dhba_drv_bus_t drv_bus,
    output dhba_drv_bus_t ctl_ret,
    output logic ctl_ret_oe,
    output logic drive_connected,
    output logic attn_to_drive,
    output dhba_pos_cmd_t pos_cmd
);
    localparam int unsigned CTL_W = $bits(dhba_ctl_bus_t);
    localparam int unsigned DRV_W = $bits(dhba_drv_bus_t);
    localparam int unsigned SYNC_W = 2 + 4 + DRIVE_W + CTL_W + DRV_W;

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    // All pins come from cables, so every one is synchronised.
    logic [SYNC_W-1:0] sync_q;
    logic s_dual;
    logic s_left_in;
    logic [1:0] s_req;
    logic [1:0] s_fin;
    logic [DRIVE_W-1:0] s_switch;
    dhba_ctl_bus_t s_ctl;
    dhba_drv_bus_t s_drv;

    dhba_sync #(.WIDTH(SYNC_W)) u_sync
    (
        .clock(clock),
        .rstn(rstn),
        .async_in({dual_mode, left_select_in, request, finish,
            select_switch, ctl_bus, drv_bus}),
        .sync_out(sync_q)
    );

    assign {s_dual, s_left_in, s_req, s_fin, s_switch, s_ctl,
        s_drv} = sync_q;

    // The synchronisers reset to zero, which would read as single mode
    // and select both hosts at once; grants and connections wait until
    // real pin levels have come through.
    logic [1:0] warm;
    logic settled;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            warm <= 2'h0;
        else if (!warm[1])
            warm <= warm + 2'h1;
    end

    assign settled = warm[1];

    // ****************************************************************
    // Arbiter
    // ****************************************************************
    dhba_arb_state_t state;
    dhba_arb_state_t next_state;
    logic [63:0] hold_count;
    logic arb_active;
    logic hold_expired;
    logic [1:0] pending;
    logic queued_right;
    logic queued_left;

    // Only the arbiter enabled by the left controller runs; it disables
    // every arbiter further down the chain.
    assign arb_active = s_dual && s_left_in;
    assign left_select_out = arb_active;
    assign hold_expired = (hold_count >= HOLD_CYCLES - 64'h1);

    // A request that arrived while the other side held the bus waits
    // here so it is served next, in arrival order.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            queued_left <= 1'b0;
            queued_right <= 1'b0;
        end
        else
        begin
            queued_left <= s_req[HOST_LEFT] && state == ARB_RIGHT;
            queued_right <= s_req[HOST_RIGHT] && state == ARB_LEFT;
        end
    end

    assign pending = s_req;

    always_comb
    begin
        next_state = state;
        case (state)
            ARB_IDLE:
            begin
                // A queued request wins over a fresh one, and a tie goes
                // to the left controller.
                if (queued_right && pending[HOST_RIGHT])
                    next_state = ARB_RIGHT;
                else if (pending[HOST_LEFT])
                    next_state = ARB_LEFT;
                else if (pending[HOST_RIGHT])
                    next_state = ARB_RIGHT;
            end
            ARB_LEFT:
            begin
                if (s_fin[HOST_LEFT] || hold_expired)
                    next_state = (queued_right && pending[HOST_RIGHT]) ?
                        ARB_RIGHT : ARB_IDLE;
            end
            ARB_RIGHT:
            begin
                if (s_fin[HOST_RIGHT] || hold_expired)
                    next_state = (queued_left && pending[HOST_LEFT]) ?
                        ARB_LEFT : ARB_IDLE;
            end
            default:
                next_state = ARB_IDLE;
        endcase
        if (!arb_active)
            next_state = ARB_IDLE;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            state <= ARB_IDLE;
        else
            state <= next_state;
    end

    // The hold timer restarts on every new grant.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            hold_count <= 64'h0;
        else if (next_state != state || state == ARB_IDLE)
            hold_count <= 64'h0;
        else
            hold_count <= hold_count + 64'h1;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            timeout_release <= 1'b0;
        else
            timeout_release <= hold_expired && state != ARB_IDLE &&
                !s_fin[state == ARB_RIGHT ? HOST_RIGHT : HOST_LEFT];
    end

    // Selects stay on until the arbiter actually hands over, which lets
    // a finished controller remain connected meanwhile.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            host_select <= 2'h0;
        else if (!settled)
            host_select <= 2'h0;
        else if (!s_dual)
            host_select <= 2'h3;
        else if (!arb_active)
            host_select <= 2'h0;
        else
            host_select <= {next_state == ARB_RIGHT,
                next_state == ARB_LEFT};
    end

    // ****************************************************************
    // Drive connection and bus buffering
    // ****************************************************************
    // Downstream interfaces rely on the chain arbiter; in single mode
    // access is always available.
    logic access;
    logic match;
    logic connect;

    assign access = settled &&
        (!s_dual || !s_left_in || state != ARB_IDLE);
    assign match = (s_ctl.drive == s_switch);
    assign connect = access && match;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            drive_connected <= 1'b0;
        else
            drive_connected <= connect;
    end

    // The bus copies follow the same decision as drive_connected, so no
    // stale word leaks out in the cycle of a connect or disconnect.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            drive_ctl <= '0;
            ctl_ret <= '0;
            attn_to_drive <= 1'b0;
        end
        else
        begin
            drive_ctl <= connect ? s_ctl : '0;
            ctl_ret <= connect ? s_drv : '0;
            attn_to_drive <= connect && s_ctl.attn_req;
        end
    end

    assign ctl_ret_oe = drive_connected;

    // ****************************************************************
    // Position command decode
    // ****************************************************************
    logic strobe_d;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            strobe_d <= 1'b0;
            pos_cmd <= '0;
        end
        else
        begin
            strobe_d <= s_ctl.addr_strobe;
            pos_cmd.valid <= drive_connected && s_ctl.addr_strobe &&
                !strobe_d && (s_ctl.cmd == CMD_SEEK ||
                s_ctl.cmd == CMD_RECAL);
            pos_cmd.recal <= (s_ctl.cmd == CMD_RECAL);
            pos_cmd.cyl <= s_ctl.cyl;
        end
    end

endmodule // dhba_arbiter
`default_nettype wire

// ==== dhba_monitor.sv ====
// Port checker for the dual host drive arbiter.
`timescale 1ns/1ps
`default_nettype none
module dhba_monitor
    import dhba_pkg::*;
#(
    parameter longint unsigned HOLD_CYCLES = HOLD_LIMIT_CYCLES
)
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic dual_mode,
    input wire logic left_select_in,
    input wire logic left_select_out,
    input wire logic [1:0] request,
    input wire logic [1:0] finish,
    input wire logic [1:0] host_select,
    input wire logic [DRIVE_W-1:0] select_switch,
    input wire dhba_ctl_bus_t drive_ctl,
    input wire logic drive_connected,
    input wire logic attn_to_drive,
    input wire dhba_pos_cmd_t pos_cmd
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rstn);
    // Six cycles cover the input synchronisers and the grant register.
    sequence s_set;
        (dual_mode && left_select_in)[*6];
    endsequence
    sequence s_tie;
        dual_mode && left_select_in && host_select == 2'h0
            && request == 2'h0 ##1 request == 2'h3;
    endsequence
    sequence s_rel;
        host_select == 2'h1 && finish[0] && !request[0]
            ##1 (finish[0] && !request[0])[*3];
    endsequence
    logic [31:0] held;
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            held <= 32'h0;
        else if ($stable(host_select) && ^host_select)
            held <= held + 32'h1;
        else
            held <= 32'h0;
    end
    AST_EXCL: assert property (s_set |-> host_select != 2'h3)
        else $error("both hosts granted");
    AST_CHAIN: assert property (s_set |-> left_select_out)
        else $error("chain output low");
    AST_SINGLE: assert property ((!dual_mode && left_select_in)[*6]
        |-> host_select == 2'h3 && !left_select_out) else $error("single");
    AST_DOWN: assert property ((dual_mode && !left_select_in)[*6]
        |-> host_select == 2'h0 && !left_select_out) else $error("down");
    AST_CAUSE: assert property ($rose(host_select[0]) && !host_select[1]
        |-> $past(request[0], 2)) else $error("grant without request");
    AST_TIE: assert property (s_tie |-> ##[1:6] host_select == 2'h1)
        else $error("tie not to left");
    AST_FREE: assert property (s_rel |=> !host_select[0])
        else $error("bus not freed");
    AST_HOLD: assert property (held < HOLD_CYCLES + 4)
        else $error("grant held too long");
    AST_MATCH: assert property (drive_connected
        |-> drive_ctl.drive == select_switch) else $error("wrong drive");
    AST_QUIET: assert property (!drive_connected
        |-> drive_ctl == '0 && !attn_to_drive) else $error("leak");
    AST_POS: assert property (pos_cmd.valid |=> !pos_cmd.valid)
        else $error("long command pulse");
endmodule // dhba_monitor
bind dhba_arbiter dhba_monitor #(.HOLD_CYCLES(HOLD_CYCLES)) mon
(
    .clock(clock),
    .rstn(rstn),
    .dual_mode(dual_mode),
    .left_select_in(left_select_in),
    .left_select_out(left_select_out),
    .request(request),
    .finish(finish),
    .host_select(host_select),
    .select_switch(select_switch),
    .drive_ctl(drive_ctl),
    .drive_connected(drive_connected),
    .attn_to_drive(attn_to_drive),
    .pos_cmd(pos_cmd)
);
`default_nettype wire

// ==== dhba_host_pair.sv ====
// Model of the two controllers sharing the bus.
`timescale 1ns/1ps
`default_nettype none
module dhba_host_pair
    import dhba_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [1:0] go,
    input wire logic [1:0] stuck,
    input wire logic [1:0] host_select,
    input wire logic [DRIVE_W-1:0] drv_num,
    output logic [1:0] request,
    output logic [1:0] finish,
    output dhba_ctl_bus_t ctl_bus
);
    logic [1:0] busy;
    logic [5:0] cnt [2];
    logic own;
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            request <= 2'h0;
            finish <= 2'h0;
            busy <= 2'h0;
            cnt <= '{6'h0, 6'h0};
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (go[i])
                begin
                    request[i] <= 1'b1;
                    finish[i] <= 1'b0;
                    cnt[i] <= 6'h0;
                end
                else if (request[i] && host_select[i])
                begin
                    busy[i] <= 1'b1;
                    cnt[i] <= cnt[i] + 6'h1;
                    if (cnt[i] == 6'h14 && !stuck[i])
                    begin
                        finish[i] <= 1'b1;
                        request[i] <= 1'b0;
                    end
                end
                else if (busy[i])
                begin
                    // A stuck host gives up only when the timer frees it.
                    busy[i] <= 1'b0;
                    request[i] <= 1'b0;
                    finish[i] <= 1'b1;
                end
            end
        end
    end
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            own <= 1'b0;
        else if (host_select == 2'h2)
            own <= 1'b1;
        else if (host_select == 2'h1)
            own <= 1'b0;
    end
    always_comb
    begin
        ctl_bus.drive = drv_num;
        ctl_bus.cmd = own ? CMD_RECAL : CMD_SEEK;
        ctl_bus.cyl = own ? 9'h1a5 : 9'h05a;
        ctl_bus.addr_strobe = busy[own] && cnt[own] == 6'h2;
        ctl_bus.attn_req = busy[own] && cnt[own] == 6'h4;
    end
endmodule // dhba_host_pair
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the dual host drive arbiter.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import dhba_pkg::*;
;
    localparam longint unsigned HC = 50;
    typedef struct {
        logic dm, ls;
        logic [1:0] go, sw, first, second;
        logic lso, con;
    } dhba_row_t;
    logic clock, rstn, dual_mode, left_select_in, left_select_out, tmo;
    logic [1:0] request, finish, host_select, go, stuck;
    logic [DRIVE_W-1:0] select_switch;
    dhba_ctl_bus_t ctl_bus, drive_ctl;
    dhba_drv_bus_t drv_bus, ctl_ret;
    dhba_pos_cmd_t pos_cmd, last_pos;
    logic ctl_ret_oe, drive_connected, attn_to_drive, timeout_release;
    int err_count, comparisons, n, attn_seen;
    dhba_row_t rows [5] = '{'{1, 1, 1, 2, 1, 0, 1, 1},
        '{1, 1, 2, 2, 2, 0, 1, 1}, '{1, 1, 3, 1, 1, 2, 1, 0},
        '{0, 1, 0, 2, 3, 3, 0, 1}, '{1, 0, 0, 2, 0, 0, 0, 1}};
    dhba_arbiter #(.HOLD_CYCLES(HC)) dut (.clock(clock), .rstn(rstn),
        .dual_mode(dual_mode), .left_select_in(left_select_in),
        .left_select_out(left_select_out), .request(request),
        .finish(finish), .host_select(host_select),
        .timeout_release(timeout_release), .select_switch(select_switch),
        .ctl_bus(ctl_bus), .drive_ctl(drive_ctl), .drv_bus(drv_bus),
        .ctl_ret(ctl_ret), .ctl_ret_oe(ctl_ret_oe),
        .drive_connected(drive_connected), .attn_to_drive(attn_to_drive),
        .pos_cmd(pos_cmd));
    dhba_host_pair hosts (.clock(clock), .rstn(rstn), .go(go),
        .stuck(stuck), .host_select(host_select), .drv_num(2'h2),
        .request(request), .finish(finish), .ctl_bus(ctl_bus));
    always @(posedge clock)
    begin
        if (pos_cmd.valid === 1'b1)
            last_pos <= pos_cmd;
        if (!rstn)
            tmo <= 1'b0;
        else if (timeout_release === 1'b1)
            tmo <= 1'b1;
        if (attn_to_drive === 1'b1)
            attn_seen++;
    end
    task step(input int k);
        repeat (k) @(posedge clock);
        #2;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task wait_hs(input logic [1:0] v);
        n = 0;
        while (host_select !== v && n < 80)
        begin
            step(1);
            n++;
        end
    endtask
    task finish_test;
        if (err_count == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial
    begin
        repeat (20000) @(posedge clock);
        err_count++;
        finish_test;
    end
    initial
    begin
        {rstn, go, stuck, dual_mode, left_select_in} = '0;
        select_switch = 2'h2;
        drv_bus = 4'ha;
        step(16);
        rstn = 1'b1;
        foreach (rows[i])
        begin
            dual_mode = rows[i].dm;
            left_select_in = rows[i].ls;
            select_switch = rows[i].sw;
            step(8);
            chk(left_select_out, rows[i].lso);
            go = rows[i].go;
            step(1);
            go = 2'h0;
            wait_hs(rows[i].first);
            chk(host_select, rows[i].first);
            step(3);
            chk(drive_connected, rows[i].con);
            chk(ctl_ret_oe, rows[i].con);
            if (rows[i].con)
                chk(ctl_ret, drv_bus);
            wait_hs(rows[i].second);
            chk(host_select, rows[i].second);
            step(40);
        end
        chk(tmo, 1'b0);
        left_select_in = 1'b1;
        step(8);
        stuck = 2'h1;
        go = 2'h1;
        step(1);
        go = 2'h2;
        step(1);
        go = 2'h0;
        wait_hs(2'h2);
        chk(host_select, 2'h2);
        chk(n + 2 >= HC - 6 && n <= HC + 6, 16'h1);
        chk(timeout_release, 1'b1);
        chk({last_pos.recal, last_pos.cyl}, 16'h05a);
        chk(attn_seen > 0, 16'h1);
        stuck = 2'h0;
        step(60);
        chk(tmo, 1'b1);
        go = 2'h1;
        step(1);
        go = 2'h0;
        wait_hs(2'h1);
        rstn = 1'b0;
        #1;
        chk(host_select, 2'h0);
        step(16);
        rstn = 1'b1;
        step(1);
        chk(host_select, 2'h0);
        step(9);
        finish_test;
    end
endmodule // tb_top
`default_nettype wire
